// *** hdl/pscr_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module pscr_regs
	import pscr_pkg::*;
#(
	parameter int CYC_PER_MS = PSCR_CLK_HZ / PSCR_MS_PER_S
)(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// Register access from the SPI client
	input  wire logic [15:0] reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	input  wire logic        spi_xfer_end,
	// Events from the measurement core
	input  wire logic        new_sample_evt,
	input  wire logic        acq_fail_evt,
	input  wire logic        selftest_fail_evt,
	input  wire logic        fw_check_fail_evt,
	// Scheduling outputs
	output logic             sample_trigger,
	output logic             selftest_start,
	output logic             fifo_clear,
	// Host pins
	output logic             power_switch_enable_out,
	output logic             aux_output_pin,
	output logic             aux_output_en,
	output logic             int_pin
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0]                sample_period_code_ff;
	logic [7:0]                selftest_interval_count_ff;
	logic [PSCR_PINFUNC_W-1:0] aux_pin_function_code_ff;
	logic [PSCR_TRIGGER_W-1:0] pulse_trigger_select_ff;
	logic [7:0]                reg_rdata_ff;
	logic                      clear_pend_ff;
	logic                      fifo_clear_ff;
	logic [7:0]                period_cnt_ff;
	logic                      sample_trigger_ff;
	logic                      selftest_start_ff;
	logic                      sw_active_ff;
	logic                      pulse_active_ff;
	logic                      int_pin_ff;
	logic                      aux_pin_ff;
	logic                      aux_en_ff;
	logic                      wr_period;
	logic                      wr_stint;
	logic                      period_tick;
	logic                      pulse_tick;
	logic                      pulse_event;
	logic                      pulse_go;
	logic [31:0]               period_limit;
	logic [31:0]               pulse_limit;
	logic [7:0]                nxt_period_cnt;

	assign wr_period = reg_wr && (reg_addr == PSCR_ADDR_PERIOD);
	assign wr_stint  = reg_wr && (reg_addr == PSCR_ADDR_STINT);

	// ----------------------------------------
	// Register writes
	// ----------------------------------------

	// Sampling period code
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			sample_period_code_ff <= PSCR_RST_PERIOD;
		end else if (wr_period) begin
			sample_period_code_ff <= reg_wdata;
		end
	end

	// Self-test interval
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			selftest_interval_count_ff <= PSCR_RST_STINT;
		end else if (wr_stint) begin
			selftest_interval_count_ff <= reg_wdata;
		end
	end

	// Auxiliary pin function, reserved bits not stored
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			aux_pin_function_code_ff <= PSCR_RST_PINFUNC;
		end else if (reg_wr && (reg_addr == PSCR_ADDR_PINFUNC)) begin
			aux_pin_function_code_ff <= reg_wdata[PSCR_PINFUNC_W-1:0];
		end
	end

	// Pulse trigger select, bits 7:6 not stored
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pulse_trigger_select_ff <= PSCR_RST_TRIGGER;
		end else if (reg_wr && (reg_addr == PSCR_ADDR_TRIGGER)) begin
			pulse_trigger_select_ff <= reg_wdata[PSCR_TRIGGER_W-1:0];
		end
	end

	// ----------------------------------------
	// Register reads
	// ----------------------------------------

	// Read data captured on the read strobe; unmapped reads zero
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata_ff <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				PSCR_ADDR_PERIOD:  reg_rdata_ff <= sample_period_code_ff;
				PSCR_ADDR_STINT:   reg_rdata_ff <= selftest_interval_count_ff;
				PSCR_ADDR_PINFUNC: reg_rdata_ff <= {5'h00, aux_pin_function_code_ff};
				PSCR_ADDR_TRIGGER: reg_rdata_ff <= {2'h0, pulse_trigger_select_ff};
				default:           reg_rdata_ff <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// FIFO clear after a period code change
	// ----------------------------------------

	// Pending until the SPI transfer ends; a new write wins over the end
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			clear_pend_ff <= 1'b0;
		end else if (wr_period && (reg_wdata != sample_period_code_ff)) begin
			clear_pend_ff <= 1'b1;
		end else if (spi_xfer_end) begin
			clear_pend_ff <= 1'b0;
		end
	end

	// One-cycle clear pulse at the transfer end
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			fifo_clear_ff <= 1'b0;
		end else begin
			fifo_clear_ff <= clear_pend_ff && spi_xfer_end;
		end
	end

	// ----------------------------------------
	// Sampling schedule
	// ----------------------------------------

	// Codes above 6 fall to the longest period
	assign period_limit = 32'(pscr_period_ms(sample_period_code_ff) * CYC_PER_MS);

	pscr_period_timer u_period (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.restart (wr_period),
		.limit   (period_limit),
		.tick    (period_tick)
	);

	// Measurement trigger, one pulse per period
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			sample_trigger_ff <= 1'b0;
		end else begin
			sample_trigger_ff <= period_tick;
		end
	end

	// ----------------------------------------
	// Self-test schedule
	// ----------------------------------------

	// Completed periods since the last self-test
	always_comb begin
		nxt_period_cnt = period_cnt_ff;
		if (wr_stint || (selftest_interval_count_ff == 8'h00)) begin
			nxt_period_cnt = 8'h00;
		end else if (period_tick) begin
			if ((period_cnt_ff + 8'h01) >= selftest_interval_count_ff) begin
				nxt_period_cnt = 8'h00;
			end else begin
				nxt_period_cnt = period_cnt_ff + 8'h01;
			end
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			period_cnt_ff <= 8'h00;
		end else begin
			period_cnt_ff <= nxt_period_cnt;
		end
	end

	// Self-test every N periods, never when N is zero
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			selftest_start_ff <= 1'b0;
		end else begin
			selftest_start_ff <= period_tick && !wr_stint
				&& (selftest_interval_count_ff != 8'h00)
				&& ((period_cnt_ff + 8'h01) >= selftest_interval_count_ff);
		end
	end

	// ----------------------------------------
	// Host interrupt pulse and power switch
	// ----------------------------------------

	// Enabled events that ask for a pulse
	assign pulse_event =
		(new_sample_evt    && pulse_trigger_select_ff[PSCR_BIT_NEWDATA]) ||
		(acq_fail_evt      && pulse_trigger_select_ff[PSCR_BIT_ACQFAIL]) ||
		(selftest_fail_evt && pulse_trigger_select_ff[PSCR_BIT_STFAIL])  ||
		(fw_check_fail_evt && pulse_trigger_select_ff[PSCR_BIT_FWCHK]);

	// Pulse starts the cycle after the switch enable asserts
	assign pulse_go = sw_active_ff && !pulse_active_ff;

	assign pulse_limit = pulse_trigger_select_ff[PSCR_BIT_LENGTH] ?
		32'(PSCR_PULSE_L_MS * CYC_PER_MS) :
		32'(PSCR_PULSE_S_MS * CYC_PER_MS);

	pscr_period_timer u_pulse (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.restart (pulse_go),
		.limit   (pulse_limit),
		.tick    (pulse_tick)
	);

	// Switch enable from event until the pulse ends
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			sw_active_ff <= 1'b0;
		end else if (pulse_event && !sw_active_ff) begin
			sw_active_ff <= 1'b1;
		end else if (pulse_active_ff && pulse_tick) begin
			sw_active_ff <= 1'b0;
		end
	end

	// Pulse window; events during a pulse are absorbed
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pulse_active_ff <= 1'b0;
		end else if (pulse_go) begin
			pulse_active_ff <= 1'b1;
		end else if (pulse_tick) begin
			pulse_active_ff <= 1'b0;
		end
	end

	// Interrupt pin level from polarity
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			int_pin_ff <= 1'b0;
		end else begin
			int_pin_ff <= (pulse_go || (pulse_active_ff && !pulse_tick))
				~^ pulse_trigger_select_ff[PSCR_BIT_POLARITY];
		end
	end

	// Auxiliary pin function decode
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			aux_pin_ff <= 1'b0;
			aux_en_ff  <= 1'b0;
		end else begin
			unique case (aux_pin_function_code_ff)
				PSCR_PIN_SW_LOW: begin
					aux_pin_ff <= !sw_active_ff;
					aux_en_ff  <= 1'b1;
				end
				PSCR_PIN_SW_HIGH: begin
					aux_pin_ff <= sw_active_ff;
					aux_en_ff  <= 1'b1;
				end
				default: begin
					aux_pin_ff <= 1'b0;
					aux_en_ff  <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata               = reg_rdata_ff;
	assign sample_trigger          = sample_trigger_ff;
	assign selftest_start          = selftest_start_ff;
	assign fifo_clear              = fifo_clear_ff;
	assign power_switch_enable_out = sw_active_ff;
	assign aux_output_pin          = aux_pin_ff;
	assign aux_output_en           = aux_en_ff;
	assign int_pin                 = int_pin_ff;

endmodule
`default_nettype wire

// *** hdl/pscr_pkg.sv ***
`default_nettype none
package pscr_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [15:0] PSCR_ADDR_PERIOD   = 16'h0050;
	localparam logic [15:0] PSCR_ADDR_STINT    = 16'h0051;
	localparam logic [15:0] PSCR_ADDR_PINFUNC  = 16'h0052;
	localparam logic [15:0] PSCR_ADDR_TRIGGER  = 16'h0053;

	// ----------------------------------------
	// Reset values and field layout
	// ----------------------------------------
	localparam logic [7:0] PSCR_RST_PERIOD  = 8'h04;
	localparam logic [7:0] PSCR_RST_STINT   = 8'hFF;
	localparam logic [2:0] PSCR_RST_PINFUNC = 3'h0;
	localparam logic [5:0] PSCR_RST_TRIGGER = 6'h3E;
	localparam logic [2:0] PSCR_PIN_SW_LOW  = 3'h4;
	localparam logic [2:0] PSCR_PIN_SW_HIGH = 3'h5;
	localparam int PSCR_PINFUNC_W     = 3;
	localparam int PSCR_TRIGGER_W     = 6;
	localparam int PSCR_BIT_POLARITY  = 5;
	localparam int PSCR_BIT_LENGTH    = 4;
	localparam int PSCR_BIT_FWCHK     = 3;
	localparam int PSCR_BIT_STFAIL    = 2;
	localparam int PSCR_BIT_ACQFAIL   = 1;
	localparam int PSCR_BIT_NEWDATA   = 0;

	// ----------------------------------------
	// Timing; clock in Hz, periods and pulses in milliseconds
	// ----------------------------------------
	localparam int PSCR_CLK_HZ     = 125000000;
	localparam int PSCR_MS_PER_S   = 1000;
	localparam int PSCR_P0_MS      = 10;
	localparam int PSCR_P1_MS      = 20;
	localparam int PSCR_P2_MS      = 40;
	localparam int PSCR_P3_MS      = 70;
	localparam int PSCR_P4_MS      = 135;
	localparam int PSCR_P5_MS      = 510;
	localparam int PSCR_P6_MS      = 1000;
	localparam int PSCR_PULSE_S_MS = 4;
	localparam int PSCR_PULSE_L_MS = 8;

	// Sampling period in ms for a code
	function automatic int pscr_period_ms(input logic [7:0] code);
		int ms;
		ms = PSCR_P6_MS;
		unique case (code)
			8'h00: ms = PSCR_P0_MS;
			8'h01: ms = PSCR_P1_MS;
			8'h02: ms = PSCR_P2_MS;
			8'h03: ms = PSCR_P3_MS;
			8'h04: ms = PSCR_P4_MS;
			8'h05: ms = PSCR_P5_MS;
			default: ms = PSCR_P6_MS;
		endcase
		return ms;
	endfunction

endpackage
`default_nettype wire

// *** hdl/pscr_period_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module pscr_period_timer
	import pscr_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// Control
	input  wire logic        restart,
	input  wire logic [31:0] limit,
	// Result
	output logic             tick
);

	logic [31:0] cnt_ff;

	// Free-running count, wraps at limit; restart zeroes it
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_ff <= 32'h0;
		end else if (restart || tick) begin
			cnt_ff <= 32'h0;
		end else begin
			cnt_ff <= cnt_ff + 32'h1;
		end
	end

	// Last cycle of the interval; limit of zero or one ticks every cycle
	assign tick = !restart && ((cnt_ff + 32'h1) >= limit);

endmodule
`default_nettype wire

// *** verification/pscr_regs_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module pscr_regs_checker
	import pscr_pkg::*;
#(
	parameter int CYC_PER_MS = 2
)(
	// Clock, reset and register port
	input wire logic        mclk,
	input wire logic        sys_rst,
	input wire logic [15:0] reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_wdata,
	input wire logic [7:0]  reg_rdata,
	input wire logic        spi_xfer_end,
	// Scheduling and pins
	input wire logic        sample_trigger,
	input wire logic        selftest_start,
	input wire logic        fifo_clear,
	input wire logic        power_switch_enable_out,
	input wire logic        aux_output_pin,
	input wire logic        aux_output_en,
	input wire logic        int_pin
);
	logic [2:0] pf_ff;
	logic [5:0] tr_ff;
	int         cnt_ff;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	// Shadow of pin function and trigger fields
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pf_ff <= PSCR_RST_PINFUNC;
			tr_ff <= PSCR_RST_TRIGGER;
		end else if (reg_wr) begin
			if (reg_addr == PSCR_ADDR_PINFUNC) pf_ff <= reg_wdata[2:0];
			if (reg_addr == PSCR_ADDR_TRIGGER) tr_ff <= reg_wdata[5:0];
		end
	end

	// Active cycles of the running pulse
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) cnt_ff <= 0;
		else if (!power_switch_enable_out) cnt_ff <= 0;
		else if (int_pin == tr_ff[PSCR_BIT_POLARITY]) cnt_ff <= cnt_ff + 1;
	end

	property p_pin_rsv;
		reg_rd && reg_addr == PSCR_ADDR_PINFUNC |=> reg_rdata[7:3] == 5'h00;
	endproperty
	a_pin_rsv: assert property (p_pin_rsv) else $error("pin reserved bits set");
	property p_trig_rsv;
		reg_rd && reg_addr == PSCR_ADDR_TRIGGER |=> reg_rdata[7:6] == 2'h0;
	endproperty
	a_trig_rsv: assert property (p_trig_rsv) else $error("trigger reserved set");
	property p_fifo;
		fifo_clear |-> $past(spi_xfer_end) ##1 !fifo_clear;
	endproperty
	a_fifo: assert property (p_fifo) else $error("fifo clear misplaced");
	property p_st_trig;
		selftest_start |-> sample_trigger;
	endproperty
	a_st_trig: assert property (p_st_trig) else $error("self-test off period");
	property p_aux_low;
		pf_ff == PSCR_PIN_SW_LOW |=> aux_output_en
			&& aux_output_pin == !$past(power_switch_enable_out);
	endproperty
	a_aux_low: assert property (p_aux_low) else $error("aux active low wrong");
	property p_aux_high;
		pf_ff == PSCR_PIN_SW_HIGH |=> aux_output_en
			&& aux_output_pin == $past(power_switch_enable_out);
	endproperty
	a_aux_high: assert property (p_aux_high) else $error("aux active high wrong");
	property p_int_start;
		$rose(power_switch_enable_out) |=> int_pin == tr_ff[PSCR_BIT_POLARITY];
	endproperty
	a_int_start: assert property (p_int_start) else $error("pulse level wrong");
	property p_int_len;
		$fell(power_switch_enable_out) |-> cnt_ff == CYC_PER_MS
			* (tr_ff[PSCR_BIT_LENGTH] ? PSCR_PULSE_L_MS : PSCR_PULSE_S_MS);
	endproperty
	a_int_len: assert property (p_int_len) else $error("pulse length wrong");
endmodule
`default_nettype wire

// *** verification/pscr_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pscr_host_model (
	// Clock
	input  wire logic        mclk,
	// Register port of the SPI client
	output logic      [15:0] reg_addr,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic      [7:0]  reg_wdata,
	output logic             spi_xfer_end
);
	// Idle bus at time zero
	initial begin
		reg_addr = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
		spi_xfer_end = 1'b0;
	end

	// One byte access; released lines show inverted values
	task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = w;
		reg_rd = !w;
		@(posedge mclk);
		#1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask

	// Chip select release
	task automatic xfer_end();
		@(posedge mclk);
		#1;
		spi_xfer_end = 1'b1;
		@(posedge mclk);
		#1;
		spi_xfer_end = 1'b0;
	endtask
endmodule
`default_nettype wire

// *** verification/tb_pressure_sampling_config_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_pressure_sampling_config_regs;
	import pscr_pkg::*;
	localparam int CPM = 2;
	logic        mclk, sys_rst, reg_wr, reg_rd, spi_xfer_end, st;
	logic [15:0] reg_addr;
	logic [7:0]  reg_wdata, reg_rdata;
	logic [3:0]  evt;
	logic [2:0]  code;
	logic        sample_trigger, selftest_start, fifo_clear, int_pin;
	logic        power_switch_enable_out, aux_output_pin, aux_output_en;
	logic        rd_seen = 1'b0;
	logic [7:0]  exp_q[$];
	int          mismatches = 0, samples_checked = 0, n, nn;
	int          ms_tab[7] = '{10, 20, 40, 70, 135, 510, 1000};
	logic [15:0] ra_tab[6] = '{16'h0050, 16'h0051, 16'h0052, 16'h0053, 16'h0054, 16'h004F};
	logic [7:0]  rv_tab[6] = '{8'h04, 8'hFF, 8'h00, 8'h3E, 8'h00, 8'h00};

	pscr_regs #(.CYC_PER_MS(CPM)) DUT (
		.mclk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .spi_xfer_end,
		.new_sample_evt(evt[0]), .acq_fail_evt(evt[1]),
		.selftest_fail_evt(evt[2]), .fw_check_fail_evt(evt[3]),
		.sample_trigger, .selftest_start, .fifo_clear,
		.power_switch_enable_out, .aux_output_pin, .aux_output_en, .int_pin
	);
	pscr_host_model host (.mclk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .spi_xfer_end);

	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bound(input int k, input int lim);
		if (k >= lim) begin
			mismatches++;
			finish_test();
		end
	endtask
	task automatic step();
		@(posedge mclk);
		#1;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		host.access(1'b1, a, d);
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.access(1'b0, a, 8'h00);
	endtask
	// Cycles up to the next sampling tick
	task automatic wait_trig();
		n = 0;
		do begin
			step();
			n++;
		end while (!sample_trigger && n < 5000);
		bound(n, 5000);
		st = selftest_start;
	endtask

	// Read results against the oldest note
	always @(posedge mclk) begin
		if (rd_seen)
			check(reg_rdata, exp_q.pop_front());
		rd_seen <= reg_rd;
	end

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	initial begin
		void'($urandom(32'h9fca));
		evt = 4'h0;
		sys_rst = 1'b1;
		repeat (8) @(posedge mclk);
		#1;
		sys_rst = 1'b0;
		// Reset values, reserved bits, unmapped places
		for (int i = 0; i < 6; i++) rd(ra_tab[i], rv_tab[i]);
		wr(16'h0054, 8'hFF);
		wr(16'h0052, 8'hFF);
		rd(16'h0052, 8'h07);
		wr(16'h0053, 8'hFF);
		rd(16'h0053, 8'h3F);
		rd(16'h0054, 8'h00);
		// Every period code, the last one random above the range
		for (int c = 0; c < 8; c++) begin
			wr(16'h0050, (c < 7) ? 8'(c) : 8'(7 + $urandom % 249));
			wait_trig();
			wait_trig();
			check(n, ms_tab[(c < 6) ? c : 6] * CPM);
		end
		// Self-test every N periods, then switched off
		wr(16'h0050, 8'h00);
		nn = 1 + $urandom % 4;
		wr(16'h0051, 8'(nn));
		rd(16'h0051, 8'(nn));
		for (int k = 1; k <= 2 * nn; k++) begin
			wait_trig();
			check(st, (k % nn) == 0);
		end
		wr(16'h0051, 8'h00);
		repeat (4) begin
			wait_trig();
			check(st, 1'b0);
		end
		// Period change empties the store once, same value does not
		wr(16'h0050, 8'h05);
		host.xfer_end();
		check(fifo_clear, 1'b1);
		step();
		check(fifo_clear, 0);
		wr(16'h0050, 8'h05);
		host.xfer_end();
		check(fifo_clear, 1'b0);
		// Every pin code with pulses of both polarities and lengths
		for (int i = 0; i < 8; i++) begin
			code = 3'(i);
			wr(16'h0053, {2'b00, code[0], code[1], 4'hF});
			wr(16'h0052, {5'h00, code});
			repeat (3) step();
			check(aux_output_en, code[2:1] == 2'b10);
			check(aux_output_pin, code == 3'h4);
			check(int_pin, !code[0]);
			evt[i % 4] = 1'b1;
			step();
			evt = 4'h0;
			nn = 0;
			while (int_pin !== code[0] && nn < 20) begin
				step();
				nn++;
			end
			bound(nn, 20);
			check(aux_output_pin, code == 3'h5);
			nn = 0;
			while (int_pin === code[0] && nn < 100) begin
				step();
				nn++;
			end
			bound(nn, 100);
			check(nn, (code[1] ? 8 : 4) * CPM);
		end
		// All events masked
		wr(16'h0053, 8'h30);
		evt = 4'hF;
		step();
		evt = 4'h0;
		repeat (4) step();
		check(power_switch_enable_out, 1'b0);
		check(int_pin, 1'b0);
		finish_test();
	end
endmodule

bind pscr_regs pscr_regs_checker #(.CYC_PER_MS(CYC_PER_MS)) u_chk (
	.mclk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .spi_xfer_end,
	.sample_trigger, .selftest_start, .fifo_clear,
	.power_switch_enable_out, .aux_output_pin, .aux_output_en, .int_pin
);
`default_nettype wire
